//--- rtl/wrsc_regs.svh
// register offsets, field positions, reset values and timing counts of the watchdog/reset block
`ifndef WRSC_REGS_SVH
`define WRSC_REGS_SVH
`define WRSC_ADDR_OPTION 4'h0
`define WRSC_ADDR_STATUS 4'h4
`define WRSC_ADDR_CTRL 4'h8
`define WRSC_ADDR_CFG 4'hC
`define WRSC_OPTION_RST 8'h3F
`define WRSC_PSA_BIT 3
`define WRSC_STAT_EXP_BIT 4
`define WRSC_STAT_PD_BIT 3
`define WRSC_STAT_SLEEP_BIT 0
`define WRSC_STAT_CORE_RST_BIT 1
`define WRSC_STAT_OSC_BIT 2
`define WRSC_CTRL_KICK_BIT 0
`define WRSC_CTRL_SLEEP_BIT 1
`define WRSC_CFG_FUSE_BIT 0
`define WRSC_CFG_PROT_BIT 1
`define WRSC_CFG_RST 2'h1
`define WRSC_PERIOD_US 18000
`define WRSC_CLK_NS 100
`define WRSC_RESP_OKAY 2'h0
`define WRSC_RESP_SLVERR 2'h2
`endif

//--- rtl/wrsc_pkg.sv
// types of the watchdog/reset block
package wrsc_pkg;
  typedef enum logic [1:0] {
    WRSC_RUN = 2'b00,
    WRSC_SLEEP = 2'b01,
    WRSC_EXTEND = 2'b10
  } wrsc_state_t;
endpackage : wrsc_pkg

//--- rtl/wrsc_top.sv
// reset extension timer, watchdog counter, sleep control and reset-cause flags
`timescale 1ns/10ps
`include "wrsc_regs.svh"

// Functional notes
// RULE1 - reset extension lasts nominally 18 ms, timed independently of the core clock
// RULE2 - core held in reset while the extension timer runs
// RULE3 - extension starts when master clear goes high
// RULE4 - watchdog expiry also starts the extension timer
// RULE5 - watchdog keeps counting while main oscillator is stopped in sleep
// RULE6 - watchdog expiry resets the device when running and wakes it from sleep
// RULE7 - watchdog reset clears the active-low expiry flag
// RULE8 - watchdog fuse at zero disables the watchdog entirely
// RULE9 - watchdog period 18 ms, prescaler lengthens it up to 1:128
// RULE10 - kick clears watchdog counter and assigned prescaler
// RULE11 - sleep clears watchdog counter and assigned prescaler
// RULE12 - flag pair encodes the last reset cause
// RULE13 - master clear pulse leaves both flags unchanged
// RULE14 - only power-up, expiry, sleep and kick alter the flags
// RULE15 - expiry and sleep act whatever the flags hold
// RULE16 - sleep stops main oscillator; port states are kept
// RULE17 - watchdog reset stays internal, never drives master clear
// RULE18 - only master clear or enabled expiry exits sleep, both fully reset
// RULE19 - watchdog counter cleared on every wake from sleep
// RULE20 - program memory readable while code protection unprogrammed
// RULE21 - wake from sleep restarts from reset state
// RULE22 - prescaler assign bit routes prescaler, rate field selects ratio
module wrsc_top
  import wrsc_pkg::*;
#(
  parameter int PERIOD_CYCLES = (`WRSC_PERIOD_US * 1000) / `WRSC_CLK_NS
)
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic master_clear_n,
  input wire logic kick_instruction,
  input wire logic sleep_instruction,
  output logic core_reset,
  output logic main_osc_enable,
  output logic expiry_flag_n,
  output logic power_down_flag_n,
  output logic verify_read_enable,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ***************************************************************
  // pin synchroniser
  // ***************************************************************
  logic master_clear_n_meta;
  logic master_clear_n_sync;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      master_clear_n_meta <= 1'b0;
      master_clear_n_sync <= 1'b0;
    end
    else
    begin
      master_clear_n_meta <= master_clear_n;
      master_clear_n_sync <= master_clear_n_meta;
    end
  end

  // ***************************************************************
  // register bus
  // ***************************************************************
  logic [7:0] option_reg;
  logic [1:0] cfg_reg;
  logic [3:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  wrsc_state_t state;
  logic [31:0] wd_count;
  logic [6:0] pre_count;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire [3:0] wr_addr = aw_take ? s_axi_awaddr : aw_addr;
  wire [31:0] wr_data = w_take ? s_axi_wdata : w_data;
  wire [3:0] wr_strb = w_take ? s_axi_wstrb : w_strb;
  wire wr_fire = (aw_held || aw_take) && (w_held || w_take) && !s_axi_bvalid;
  wire wr_option = wr_fire && wr_addr == `WRSC_ADDR_OPTION && wr_strb[0];
  wire wr_ctrl = wr_fire && wr_addr == `WRSC_ADDR_CTRL && wr_strb[0];
  wire wr_cfg = wr_fire && wr_addr == `WRSC_ADDR_CFG && wr_strb[0];
  wire wr_known = wr_addr == `WRSC_ADDR_OPTION || wr_addr == `WRSC_ADDR_CTRL || wr_addr == `WRSC_ADDR_CFG;
  wire rd_take = s_axi_arvalid && s_axi_arready;
  wire [31:0] status_word = {27'h0, expiry_flag_n, power_down_flag_n, main_osc_enable, core_reset,
                             state == WRSC_SLEEP};
  wire rd_known = s_axi_araddr == `WRSC_ADDR_STATUS || s_axi_araddr == `WRSC_ADDR_CFG;
  wire [31:0] rd_word = s_axi_araddr == `WRSC_ADDR_STATUS ? status_word :
                        s_axi_araddr == `WRSC_ADDR_CFG ? {30'h0, cfg_reg} : 32'h0;

  // ***************************************************************
  // watchdog counter and prescaler
  // ***************************************************************
  function automatic logic [6:0] wrsc_ratio_mask(input logic [2:0] rate);
    wrsc_ratio_mask = 7'((8'h01 << rate) - 8'h01);
  endfunction : wrsc_ratio_mask

  wire fuse_on = cfg_reg[`WRSC_CFG_FUSE_BIT];
  wire pre_to_wd = option_reg[`WRSC_PSA_BIT];
  wire [6:0] pre_mask = pre_to_wd ? wrsc_ratio_mask(option_reg[2:0]) : 7'h00;
  wire kick = (kick_instruction || (wr_ctrl && wr_data[`WRSC_CTRL_KICK_BIT])) && state == WRSC_RUN;
  wire go_sleep = (sleep_instruction || (wr_ctrl && wr_data[`WRSC_CTRL_SLEEP_BIT])) && state == WRSC_RUN;
  wire wd_tick = (pre_count & pre_mask) == pre_mask;
  wire wd_expire = fuse_on && wd_tick && wd_count == 32'(PERIOD_CYCLES - 1); // [RULE8] [RULE15]
  wire master_clear_n_low = !master_clear_n_sync;
  wire wake = state == WRSC_SLEEP && (master_clear_n_low || wd_expire); // [RULE18]
  wire wd_clear = kick || go_sleep || wake || state == WRSC_EXTEND || master_clear_n_low || !fuse_on; // [RULE10] [RULE11] [RULE19]
  wire [31:0] next_wd_count = wd_clear || wd_expire ? 32'h0 : wd_tick ? wd_count + 32'h1 : wd_count;
  wire [6:0] next_pre_count = wd_clear || wd_tick ? 7'h00 : pre_count + 7'h01; // [RULE22] [RULE9]

  // ***************************************************************
  // reset extension timer
  // ***************************************************************
  logic [31:0] ext_count;
  wire ext_done = ext_count == 32'(PERIOD_CYCLES - 1); // [RULE1]
  wrsc_state_t next_state;

  always_comb
  begin
    next_state = state;
    unique case (state)
      WRSC_RUN:
        if (master_clear_n_low || wd_expire)
          next_state = WRSC_EXTEND; // [RULE4] [RULE6]
        else if (go_sleep)
          next_state = WRSC_SLEEP;
      WRSC_SLEEP:
        if (wake)
          next_state = WRSC_EXTEND; // [RULE21]
      WRSC_EXTEND:
        if (master_clear_n_sync && ext_done)
          next_state = WRSC_RUN; // [RULE3]
      default:
        next_state = WRSC_EXTEND;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= WRSC_EXTEND;
      ext_count <= 32'h0;
      wd_count <= 32'h0;
      pre_count <= 7'h00;
    end
    else
    begin
      state <= next_state;
      ext_count <= (state != WRSC_EXTEND || master_clear_n_low || ext_done) ? 32'h0 : ext_count + 32'h1; // [RULE3]
      wd_count <= next_wd_count; // [RULE5]
      pre_count <= next_pre_count;
    end
  end

  // ***************************************************************
  // outputs and reset-cause flags
  // ***************************************************************
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      core_reset <= 1'b1;
      main_osc_enable <= 1'b1;
      expiry_flag_n <= 1'b1; // [RULE12]
      power_down_flag_n <= 1'b1;
      verify_read_enable <= 1'b1;
    end
    else
    begin
      core_reset <= next_state == WRSC_EXTEND; // [RULE2] [RULE17]
      main_osc_enable <= next_state != WRSC_SLEEP; // [RULE16]
      verify_read_enable <= !cfg_reg[`WRSC_CFG_PROT_BIT]; // [RULE20]
      if (wd_expire)
        expiry_flag_n <= 1'b0; // [RULE7] [RULE14]
      else if (kick || go_sleep)
        expiry_flag_n <= 1'b1;
      if (go_sleep)
        power_down_flag_n <= 1'b0; // [RULE14]
      else if (kick)
        power_down_flag_n <= 1'b1; // [RULE13]
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      option_reg <= `WRSC_OPTION_RST;
      cfg_reg <= `WRSC_CFG_RST;
      aw_addr <= 4'h0;
      aw_held <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      w_held <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `WRSC_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `WRSC_RESP_OKAY;
    end
    else
    begin
      if (core_reset && state == WRSC_EXTEND && ext_count == 32'h0)
        option_reg <= `WRSC_OPTION_RST;
      else if (wr_option)
        option_reg <= wr_data[7:0];
      if (wr_cfg)
        cfg_reg <= wr_data[1:0];
      if (aw_take)
        aw_addr <= s_axi_awaddr;
      if (w_take)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      aw_held <= (aw_held || aw_take) && !wr_fire;
      w_held <= (w_held || w_take) && !wr_fire;
      s_axi_awready <= !(aw_held || aw_take) || wr_fire;
      s_axi_wready <= !(w_held || w_take) || wr_fire;
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? `WRSC_RESP_OKAY : `WRSC_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (rd_take)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_known ? `WRSC_RESP_OKAY : `WRSC_RESP_SLVERR;
        s_axi_arready <= 1'b0;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  chk_core_held_ext: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE2]
    state == WRSC_EXTEND |-> core_reset)
    else $error("core not held in reset during extension");
  chk_expiry_clears_flag: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE7]
    wd_expire |=> !expiry_flag_n && core_reset)
    else $error("expiry did not clear flag or reset core");
  chk_fuse_off_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE8]
    !fuse_on |-> !wd_expire)
    else $error("watchdog expired while disabled");
  chk_kick_clears_wd: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE10]
    kick && !wd_expire |=> wd_count == 32'h0 && pre_count == 7'h00 && expiry_flag_n && power_down_flag_n)
    else $error("kick did not clear watchdog or set flags");
  chk_sleep_flags: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE14]
    go_sleep && !wd_expire && !master_clear_n_low |=>
    expiry_flag_n && !power_down_flag_n && !main_osc_enable && wd_count == 32'h0)
    else $error("sleep entry wrong");
  chk_master_clear_n_keeps_flags: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE13]
    master_clear_n_low && !kick && !go_sleep && !wd_expire |=> $stable(expiry_flag_n) && $stable(power_down_flag_n))
    else $error("master clear changed flags");
  chk_wake_resets: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE18]
    wake |=> core_reset && main_osc_enable && wd_count == 32'h0)
    else $error("wake did not reset device");
  chk_ext_start: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE3]
    state == WRSC_EXTEND && master_clear_n_low |=> state == WRSC_EXTEND && ext_count == 32'h0)
    else $error("extension ran while master clear low");

  // ***************************************************************
  // timer, sleep, flag, protection, option and bus checks
  // ***************************************************************
  chk_ext_full_length: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE1]
    $fell(core_reset) |-> $past(ext_count) == 32'(PERIOD_CYCLES - 1))
    else $error("extension ended early or late");
  chk_core_free_run: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE2]
    state == WRSC_RUN |-> !core_reset)
    else $error("core held in reset while running");
  chk_master_clear_n_enters_ext: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE18]
    master_clear_n_low && state != WRSC_EXTEND |=> core_reset && state == WRSC_EXTEND)
    else $error("master clear did not reset device");
  chk_expiry_starts_ext: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE4]
    wd_expire |=> state == WRSC_EXTEND && ext_count == 32'h0)
    else $error("expiry did not restart extension");
  chk_wd_counts_sleep: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE5]
    state == WRSC_SLEEP && fuse_on && wd_tick && !wd_expire && !master_clear_n_low |=>
    wd_count == $past(wd_count) + 32'h1)
    else $error("watchdog stalled in sleep");
  chk_osc_off_sleep: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE16]
    state == WRSC_SLEEP |-> !main_osc_enable && !core_reset)
    else $error("oscillator running while asleep");
  chk_sleep_exit_only: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE18]
    state == WRSC_SLEEP && !master_clear_n_low && !wd_expire |=> state == WRSC_SLEEP)
    else $error("sleep left without wake event");
  chk_wd_clear_ext: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE19]
    state == WRSC_EXTEND |-> wd_count == 32'h0 && pre_count == 7'h00)
    else $error("watchdog not clear during extension");
  chk_flags_only_events: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE14]
    !wd_expire && !kick && !go_sleep |=> $stable(expiry_flag_n) && $stable(power_down_flag_n))
    else $error("flags changed without event");
  chk_prot_blocks_read: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE20]
    cfg_reg[`WRSC_CFG_PROT_BIT] |=> !verify_read_enable)
    else $error("readout allowed while protected");
  chk_option_default: assert property (@(posedge clk_sys) disable iff (!arst_n) // [RULE22]
    state == WRSC_EXTEND && ext_count == 32'h1 |-> option_reg == `WRSC_OPTION_RST)
    else $error("option not restored on reset");
  chk_bresp_holds: assert property (@(posedge clk_sys) disable iff (!arst_n)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_rdata_holds: assert property (@(posedge clk_sys) disable iff (!arst_n)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped early");
  chk_one_read: assert property (@(posedge clk_sys) disable iff (!arst_n)
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answer pending");

endmodule : wrsc_top

//--- sim/wrsc_master_clear_n_src.sv
// external reset source on the master-clear pin
`timescale 1ns/10ps
module wrsc_master_clear_n_src (
  input wire logic clk_sys,
  output logic master_clear_n
);
  // ********
  // pin drive
  // ********
  initial master_clear_n = 1'b1;
  // low pulse of n cycles, then back high
  task automatic pulse(input int n);
    @(posedge clk_sys);
    master_clear_n <= 1'b0;
    repeat (n) @(posedge clk_sys);
    master_clear_n <= 1'b1;
  endtask : pulse
endmodule : wrsc_master_clear_n_src

//--- sim/wrsc_top_tb.sv
// self-checking bench of the watchdog/reset block
`timescale 1ns/10ps
`include "wrsc_regs.svh"
module wrsc_top_tb;
  import wrsc_pkg::*;
  localparam logic [3:0] OPT = `WRSC_ADDR_OPTION;
  localparam logic [3:0] CFG = `WRSC_ADDR_CFG;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic kick = 1'b0;
  logic slp = 1'b0;
  wire logic master_clear_n;
  logic core_reset, main_osc_enable, expiry_flag_n, power_down_flag_n, verify_read_enable;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int miscompares = 0;
  int num_checks = 0;
  wrsc_top #(.PERIOD_CYCLES(20)) i_wrsc_top (.clk_sys(clk_sys), .arst_n(arst_n),
    .master_clear_n(master_clear_n), .kick_instruction(kick), .sleep_instruction(slp),
    .core_reset(core_reset), .main_osc_enable(main_osc_enable), .expiry_flag_n(expiry_flag_n),
    .power_down_flag_n(power_down_flag_n), .verify_read_enable(verify_read_enable),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  wrsc_master_clear_n_src i_wrsc_master_clear_n_src (.clk_sys(clk_sys), .master_clear_n(master_clear_n));
  initial
  begin
    forever #50 clk_sys = ~clk_sys;
  end
  // ********
  // helpers
  // ********
  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge clk_sys);
      aw = aw | awready;
      w = w | wready;
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    do @(posedge clk_sys); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk_word({30'h0, bresp}, {30'h0, er});
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_sys); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_sys); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk_word({30'h0, rresp}, {30'h0, er});
    if (er == 2'h0) chk_word(rdata, ed);
  endtask : axi_rd
  task automatic core_op(input logic sleep_op);
    @(posedge clk_sys);
    if (sleep_op)
      slp <= 1'b1;
    else
      kick <= 1'b1;
    @(posedge clk_sys);
    slp <= 1'b0;
    kick <= 1'b0;
    #1;
  endtask : core_op
  task automatic wait_core(input logic v, input int n);
    int i;
    i = 0;
    while (i < n && core_reset !== v)
    begin
      @(posedge clk_sys);
      #1 i++;
    end
    chk_bit(core_reset, v);
  endtask : wait_core
  task automatic flags(input logic e, input logic p);
    chk_bit(expiry_flag_n, e);
    chk_bit(power_down_flag_n, p);
  endtask : flags
  task automatic give_verdict();
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  // ********
  // tests
  // ********
  task automatic t_por();
    wait_core(1'b0, 60);
    flags(1'b1, 1'b1);
    axi_rd(`WRSC_ADDR_STATUS, 32'h1C, 2'h0);
    axi_rd(CFG, 32'h1, 2'h0);
    axi_rd(4'h2, 32'h0, 2'h2);
    axi_wr(`WRSC_ADDR_STATUS, 32'h0, 2'h2);
    $display("t_por done");
  endtask : t_por
  task automatic t_kick_run();
    axi_wr(OPT, 32'h0, 2'h0);
    repeat (6) core_op(1'b0);
    repeat (6) core_op(1'b0);
    axi_wr(`WRSC_ADDR_CTRL, 32'h1, 2'h0);
    flags(1'b1, 1'b1);
    wait_core(1'b1, 40);
    flags(1'b0, 1'b1);
    wait_core(1'b0, 60);
    $display("t_kick_run done");
  endtask : t_kick_run
  task automatic t_sleep_wdt();
    axi_wr(OPT, 32'h0, 2'h0);
    core_op(1'b1);
    flags(1'b1, 1'b0);
    chk_bit(main_osc_enable, 1'b0);
    wait_core(1'b1, 40);
    flags(1'b0, 1'b0);
    wait_core(1'b0, 60);
    chk_bit(main_osc_enable, 1'b1);
    repeat (10) @(posedge clk_sys);
    #1 chk_bit(core_reset, 1'b0);
    $display("t_sleep_wdt done");
  endtask : t_sleep_wdt
  task automatic t_master_clear_n();
    axi_wr(`WRSC_ADDR_CTRL, 32'h2, 2'h0);
    chk_bit(main_osc_enable, 1'b0);
    i_wrsc_master_clear_n_src.pulse(4);
    wait_core(1'b1, 10);
    flags(1'b1, 1'b0);
    wait_core(1'b0, 60);
    i_wrsc_master_clear_n_src.pulse(4);
    wait_core(1'b1, 10);
    flags(1'b1, 1'b0);
    wait_core(1'b0, 60);
    $display("t_master_clear_n done");
  endtask : t_master_clear_n
  task automatic t_fuse_presc();
    axi_wr(CFG, 32'h2, 2'h0);
    axi_wr(OPT, 32'h0, 2'h0);
    #1 chk_bit(verify_read_enable, 1'b0);
    repeat (100) @(posedge clk_sys);
    #1 chk_bit(core_reset, 1'b0);
    axi_rd(CFG, 32'h2, 2'h0);
    axi_wr(CFG, 32'h1, 2'h0);
    axi_wr(OPT, 32'h9, 2'h0);
    #1 chk_bit(verify_read_enable, 1'b1);
    core_op(1'b0);
    repeat (30) @(posedge clk_sys);
    #1 chk_bit(core_reset, 1'b0);
    wait_core(1'b1, 30);
    flags(1'b0, 1'b1);
    $display("t_fuse_presc done");
  endtask : t_fuse_presc
  task automatic t_power_cycle();
    @(posedge clk_sys);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    #1 flags(1'b1, 1'b1);
    chk_bit(core_reset, 1'b1);
    wait_core(1'b0, 60);
    axi_rd(`WRSC_ADDR_STATUS, 32'h1C, 2'h0);
    $display("t_power_cycle done");
  endtask : t_power_cycle
  initial
  begin
    #(100 * 20000);
    miscompares++;
    give_verdict();
  end
  initial
  begin
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_por();
    t_kick_run();
    t_sleep_wdt();
    t_master_clear_n();
    t_fuse_presc();
    t_power_cycle();
    give_verdict();
  end
endmodule : wrsc_top_tb
